// ==== rtl/formatter_pkg.sv ====
// constants for the id-less sector formatter; its check-byte generator uses none of them
// assumes a single 25 MHz controller clock; all times below convert to its cycles
package formatter_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // wedge geometry: ninety wedges a turn, seventy-five turns a second
  localparam int WEDGES_PER_REV = 90;
  localparam int SAMPLE_RATE_HZ = 6750;
  localparam int WEDGE_W = 7;
  localparam logic [6:0] WEDGE_LAST = 7'h59;
  // wedge field lengths in ns; counts round up to whole cycles
  localparam int AGC_NS = 2000;
  localparam int SAM_NS = 400;
  localparam int TRACK_NS = 1600;
  localparam int BURST_NS = 4000;
  localparam int AGC_CYC = (AGC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAM_CYC = (SAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_CYC = (TRACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_CYC = (BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sector timer: the 12-bit sector mark meets the top bits of a 16-bit timer
  localparam int TIMER_W = 16;
  localparam int MARK_W = 12;
  localparam int MARK_LSB = 4;
  // descriptor byte 0 and byte 1 layout
  localparam int PARITY_BIT = 7;
  localparam int MARK_HI_LSB = 0;
  localparam int BRK1_LSB = 4;
  // break counts are stored scaled; shift turns them into byte positions
  localparam int BRK1_SHIFT = 5;
  localparam int BRK2_SHIFT = 1;
  localparam int DEFECT_BIT = 0;
  localparam int DESC_BYTES_MAX = 4;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  typedef enum {F_IDLE, F_AGC, F_SAM, F_TRACK, F_BURST} field_e;
  typedef enum {S_IDLE, S_FETCH, S_DEFECT, S_CHECK, S_WEDGE, S_MARK, S_DATA, S_SKIP, S_ECC, S_DONE} seq_e;
endpackage

// ==== rtl/check_byte_gen.sv ====
// byte-wide check generator for the sector data path
// assumes bytes arrive one a cycle on data_valid; clear starts a new sector
`timescale 1ns/100ps
module check_byte_gen #(
  parameter int CHECK_BYTES = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic data_valid,
  input wire logic [7:0] data,
  output logic [8*CHECK_BYTES-1:0] check
);
  logic [7:0] acc [CHECK_BYTES];
  logic [7:0] next_acc [CHECK_BYTES];
  logic [7:0] feedback;

  // division remainder; feeding the appended bytes back in leaves all zero
  assign feedback = data ^ acc[CHECK_BYTES-1];

  genvar g;
  generate
    for (g = 0; g < CHECK_BYTES; g++) begin : g_lane
      always_comb begin
        next_acc[g] = acc[g];
        if (clear) begin
          next_acc[g] = 8'h00;
        end else if (data_valid) begin
          next_acc[g] = (g == 0) ? feedback : (acc[(g == 0) ? 0 : g-1] ^ feedback);
        end
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          acc[g] <= 8'h00;
        end else begin
          acc[g] <= next_acc[g];
        end
      end
      assign check[8*g +: 8] = acc[g];
    end
  endgenerate
endmodule

// ==== rtl/idless_sector_formatter.sv ====
// id-less sector formatter: wedge timing, descriptor fetch, read and write data paths
// assumes a buffer controller answering byte requests and a read/write channel on pins
`timescale 1ns/100ps
import formatter_pkg::*;

module idless_sector_formatter #(
  parameter int SECTOR_BYTES = 512,
  parameter int CHECK_BYTES = 4,
  parameter int BIT_CYCLES = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic servo_mark_found,
  input wire logic index_pulse,
  output logic [formatter_pkg::WEDGE_W-1:0] wedge_count,
  output logic position_sample,
  output logic burst_window,
  input wire logic op_start,
  input wire logic op_write,
  input wire logic triple_split,
  input wire logic parity_enable,
  input wire logic [15:0] desc_addr,
  input wire logic [15:0] defect_addr,
  input wire logic [2:0] head_in,
  output logic buf_req,
  output logic [15:0] buf_addr,
  input wire logic buf_ack,
  input wire logic [7:0] buf_rdata,
  output logic busy,
  output logic done,
  output logic op_error,
  output logic defect_hit,
  output logic parity_irq,
  input wire logic nrz_read_bit,
  input wire logic nrz_read_strobe,
  output logic read_gate,
  output logic [15:0] rd_word,
  output logic rd_word_valid,
  output logic ecc_valid,
  output logic corr_needed,
  output logic [1:0] corr_class,
  input wire logic [7:0] wr_byte,
  input wire logic wr_byte_valid,
  output logic wr_byte_ready,
  output logic write_gate,
  output logic preamp_write_mode,
  output logic [2:0] head_select,
  output logic nrz_write_bit
);
  import formatter_pkg::*;
  localparam int TOTAL_BYTES = SECTOR_BYTES + CHECK_BYTES;

  // pin synchroniser: stage one feeds stage two only; stage two against stage three gives edges
  logic [3:0] sync1, sync2, sync3;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= {nrz_read_bit, nrz_read_strobe, index_pulse, servo_mark_found};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic mark_evt, index_evt, bit_evt;
  assign mark_evt = sync2[0] & ~sync3[0];
  assign index_evt = sync2[1] & ~sync3[1];
  assign bit_evt = sync2[2] & ~sync3[2];

  // wedge timing group
  field_e field, next_field;
  logic [11:0] fcnt, next_fcnt;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [WEDGE_W-1:0] wedge, next_wedge;
  logic index_seen, next_index_seen;
  logic next_sample;
  always_comb begin
    next_field = field;
    next_fcnt = fcnt + 12'h001;
    next_timer = (&timer) ? timer : timer + 16'h0001;
    next_wedge = wedge;
    next_index_seen = index_seen | index_evt;
    next_sample = 1'b0;
    if (mark_evt) begin
      next_timer = '0;
      next_field = F_AGC;
      next_fcnt = 12'h000;
      next_index_seen = 1'b0;
      // wrap after the ninetieth wedge, or realign at the index
      next_wedge = (index_seen || index_evt || wedge == WEDGE_LAST) ? '0 : wedge + 7'h01;
    end else begin
      // field edges by counting clocks; no recovered clock in the servo area
      case (field)
        F_AGC: if (fcnt == 12'(AGC_CYC - 1)) begin next_field = F_SAM; next_fcnt = '0; end
        F_SAM: if (fcnt == 12'(SAM_CYC - 1)) begin next_field = F_TRACK; next_fcnt = '0; end
        F_TRACK: if (fcnt == 12'(TRACK_CYC - 1)) begin next_field = F_BURST; next_fcnt = '0; end
        F_BURST: if (fcnt == 12'(BURST_CYC - 1)) begin
          next_field = F_IDLE;
          next_sample = 1'b1;
        end
        F_IDLE: next_fcnt = '0;
        default: next_field = F_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      field <= F_IDLE;
      fcnt <= '0;
      timer <= '0;
      wedge <= '0;
      index_seen <= 1'b0;
      position_sample <= 1'b0;
    end else begin
      field <= next_field;
      fcnt <= next_fcnt;
      timer <= next_timer;
      wedge <= next_wedge;
      index_seen <= next_index_seen;
      position_sample <= next_sample;
    end
  end
  assign wedge_count = wedge;
  assign burst_window = (field == F_BURST);

  // sequencer group: descriptor, defect, wait, data, check bytes
  seq_e state, next_state;
  logic [7:0] desc [DESC_BYTES_MAX];
  logic [7:0] next_desc [DESC_BYTES_MAX];
  logic [2:0] fidx, next_fidx;
  logic [9:0] bcnt, next_bcnt;
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitn, next_bitn;
  logic [7:0] pace, next_pace;
  logic [7:0] lowbyte, next_lowbyte;
  logic half, next_half;
  logic brk_done1, next_brk_done1, brk_done2, next_brk_done2, skip_mark, next_skip_mark;
  logic [8*CHECK_BYTES-1:0] chk, chk_hold, next_chk_hold;
  logic next_done, next_err, next_defect, next_pirq, next_word_valid, next_ecc_valid, next_corr_needed;
  logic [1:0] next_corr_class;
  logic [15:0] next_rd_word;
  logic gen_clear, gen_valid;
  logic [7:0] gen_data;
  logic [WEDGE_W-1:0] dwedge;
  logic [MARK_W-1:0] smark;
  logic [9:0] brk1_pos, brk2_pos;
  logic parity_ok, byte_end, in_check;
  logic [7:0] load_byte;
  logic [2:0] nz;

  // descriptor fields
  assign dwedge = desc[0][WEDGE_W-1:0];
  assign smark = {desc[1][MARK_HI_LSB +: 4], desc[2]};
  assign brk1_pos = 10'({desc[1][BRK1_LSB +: 4], 5'b0});
  assign brk2_pos = 10'({desc[3], 1'b0});
  // odd parity over three or four descriptor bytes
  assign parity_ok = ^{desc[0], desc[1], desc[2], (triple_split ? desc[3] : 8'h00)};
  assign in_check = (bcnt >= 10'(SECTOR_BYTES));
  assign byte_end = op_write ? (bitn == 4'h7 && pace == 8'(BIT_CYCLES - 1)) : (bitn == 4'h7 && bit_evt);
  // the generator takes wr_byte on write and the assembled read byte on read
  // reads also feed the received check bytes, so a clean sector leaves a zero remainder
  assign gen_data = op_write ? wr_byte : {shreg[6:0], sync3[3]};
  assign gen_valid = (state == S_DATA) &&
                     (op_write ? (!in_check && bitn == 4'h0 && pace == 8'h00 && wr_byte_valid) : byte_end);
  // byte that the write serialiser starts on: held check byte or fresh data byte
  assign load_byte = in_check ? chk_hold[8*(TOTAL_BYTES-1-int'(bcnt)) +: 8] : wr_byte;
  assign gen_clear = (state == S_MARK);
  check_byte_gen #(.CHECK_BYTES(CHECK_BYTES)) u_check (
    .clk(clk),
    .resetn(resetn),
    .clear(gen_clear),
    .data_valid(gen_valid),
    .data(gen_data),
    .check(chk)
  );

  always_comb begin
    next_state = state;
    for (int i = 0; i < DESC_BYTES_MAX; i++) next_desc[i] = desc[i];
    next_fidx = fidx;
    next_bcnt = bcnt;
    next_shreg = shreg;
    next_bitn = bitn;
    next_pace = pace;
    next_lowbyte = lowbyte;
    next_half = half;
    next_brk_done1 = brk_done1;
    next_brk_done2 = brk_done2;
    next_skip_mark = skip_mark;
    next_chk_hold = chk_hold;
    next_done = 1'b0;
    next_err = op_error;
    next_defect = defect_hit;
    next_pirq = 1'b0;
    next_word_valid = 1'b0;
    next_rd_word = rd_word;
    next_ecc_valid = 1'b0;
    next_corr_needed = corr_needed;
    next_corr_class = corr_class;
    nz = 3'h0;
    case (state)
      S_IDLE: if (op_start) begin
        next_state = S_FETCH;
        next_fidx = '0;
        next_err = 1'b0;
        next_defect = 1'b0;
      end
      // descriptor bytes one by one from the buffer
      S_FETCH: if (buf_ack) begin
        next_desc[fidx[1:0]] = buf_rdata;
        next_fidx = fidx + 3'h1;
        if (fidx == (triple_split ? 3'h3 : 3'h2)) next_state = S_DEFECT;
      end
      // defect list lives apart from the descriptor
      S_DEFECT: if (buf_ack) begin
        next_defect = buf_rdata[DEFECT_BIT];
        next_state = S_CHECK;
      end
      S_CHECK: begin
        if (parity_enable && !parity_ok) begin
          next_pirq = 1'b1;
          next_err = 1'b1;
          next_state = S_DONE;
        end else if (defect_hit) begin
          next_state = S_DONE;
        end else begin
          next_state = S_WEDGE;
        end
      end
      // only the wedge named in the descriptor; wait for its mark
      S_WEDGE: if (mark_evt && next_wedge == dwedge) next_state = S_MARK;
      S_MARK: begin
        next_bcnt = '0;
        next_bitn = '0;
        next_pace = '0;
        next_half = 1'b0;
        next_brk_done1 = 1'b0;
        next_brk_done2 = 1'b0;
        if (mark_evt) next_state = S_WEDGE; // sector missed in this wedge
        else if (timer[TIMER_W-1 -: MARK_W] == smark) next_state = S_DATA;
      end
      S_DATA: begin
        if (op_write) begin
          // load next data byte or held check byte; the pin indexes it msb first
          if (bitn == 4'h0 && pace == 8'h00) begin
            if (in_check) begin
              next_shreg = load_byte;
            end else if (wr_byte_valid) begin
              next_shreg = wr_byte;
            end else begin
              next_err = 1'b1; // buffer underrun cannot be recovered mid-sector
              next_state = S_DONE;
            end
          end
          next_pace = (pace == 8'(BIT_CYCLES - 1)) ? 8'h00 : pace + 8'h01;
          if (pace == 8'(BIT_CYCLES - 1)) begin
            next_bitn = bitn + 4'h1;
          end
        end else if (bit_evt) begin
          next_shreg = {shreg[6:0], sync3[3]};
          next_bitn = bitn + 4'h1;
        end
        if (byte_end) begin
          next_bitn = '0;
          next_bcnt = bcnt + 10'h001;
          if (!op_write && !in_check) begin
            // pair bytes, first byte in the low half
            next_half = ~half;
            next_lowbyte = {shreg[6:0], sync3[3]};
            next_rd_word = {shreg[6:0], sync3[3], lowbyte};
            next_word_valid = half;
          end
          if (bcnt == 10'(SECTOR_BYTES - 1)) next_chk_hold = op_write ? chk : next_chk_hold;
          if (bcnt == 10'(TOTAL_BYTES - 1)) begin
            next_state = op_write ? S_DONE : S_ECC;
          end else if (!brk_done1 && brk1_pos != 10'h000 && next_bcnt == brk1_pos) begin
            next_brk_done1 = 1'b1;
            next_skip_mark = 1'b0;
            next_state = S_SKIP;
          end else if (triple_split && brk_done1 && !brk_done2 && brk2_pos != 10'h000 && next_bcnt == brk2_pos) begin
            next_brk_done2 = 1'b1;
            next_skip_mark = 1'b0;
            next_state = S_SKIP;
          end
        end
      end
      // gates down across the wedge, resume after its burst field ends
      S_SKIP: begin
        if (mark_evt) next_skip_mark = 1'b1;
        if (skip_mark && position_sample) next_state = S_DATA;
      end
      // remainder over data plus check bytes decides the correction class
      S_ECC: begin
        for (int i = 0; i < CHECK_BYTES; i++) nz = nz + {2'b00, (chk[8*i +: 8] != 8'h00)};
        next_ecc_valid = 1'b1;
        next_corr_needed = (nz != 3'h0);
        next_corr_class = (nz == 3'h0) ? 2'h0 : 2'(nz - 3'h1);
        next_state = S_DONE;
      end
      S_DONE: begin
        next_done = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= S_IDLE;
      for (int i = 0; i < DESC_BYTES_MAX; i++) desc[i] <= 8'h00;
      fidx <= '0;
      bcnt <= '0;
      shreg <= 8'h00;
      bitn <= '0;
      pace <= 8'h00;
      lowbyte <= 8'h00;
      half <= 1'b0;
      brk_done1 <= 1'b0;
      brk_done2 <= 1'b0;
      skip_mark <= 1'b0;
      chk_hold <= '0;
      done <= 1'b0;
      op_error <= 1'b0;
      defect_hit <= 1'b0;
      parity_irq <= 1'b0;
      rd_word <= 16'h0000;
      rd_word_valid <= 1'b0;
      ecc_valid <= 1'b0;
      corr_needed <= 1'b0;
      corr_class <= 2'h0;
      head_select <= 3'h0;
    end else begin
      state <= next_state;
      for (int i = 0; i < DESC_BYTES_MAX; i++) desc[i] <= next_desc[i];
      fidx <= next_fidx;
      bcnt <= next_bcnt;
      shreg <= next_shreg;
      bitn <= next_bitn;
      pace <= next_pace;
      lowbyte <= next_lowbyte;
      half <= next_half;
      brk_done1 <= next_brk_done1;
      brk_done2 <= next_brk_done2;
      skip_mark <= next_skip_mark;
      chk_hold <= next_chk_hold;
      done <= next_done;
      op_error <= next_err;
      defect_hit <= next_defect;
      parity_irq <= next_pirq;
      rd_word <= next_rd_word;
      rd_word_valid <= next_word_valid;
      ecc_valid <= next_ecc_valid;
      corr_needed <= next_corr_needed;
      corr_class <= next_corr_class;
      if (state == S_IDLE && op_start) head_select <= head_in;
    end
  end

  // buffer requests and channel pins
  assign buf_req = (state == S_FETCH) || (state == S_DEFECT);
  assign buf_addr = (state == S_FETCH) ? desc_addr + {13'h0000, fidx} : (state == S_DEFECT) ? defect_addr : RESET_ADDR;
  assign busy = (state != S_IDLE);
  // preamp is in write mode from the wedge wait onward, ahead of the gate
  assign preamp_write_mode = op_write && (state == S_WEDGE || state == S_MARK || state == S_DATA || state == S_SKIP);
  assign write_gate = op_write && (state == S_DATA);
  assign read_gate = !op_write && (state == S_DATA);
  // the first bit of a byte comes straight from the load source, so no bit is lost at the gate
  assign nrz_write_bit = write_gate ? ((bitn == 4'h0 && pace == 8'h00) ? load_byte[7] :
                         shreg[3'(4'h7 - bitn)]) : 1'b0;
  assign wr_byte_ready = gen_valid && op_write;

  a_wedge_wrap: assert property (@(posedge clk) disable iff (!resetn)
    (mark_evt && wedge == WEDGE_LAST) |=> wedge == 7'h00) else $error("wedge count did not wrap");
  a_wedge_range: assert property (@(posedge clk) disable iff (!resetn)
    wedge < 7'(WEDGES_PER_REV)) else $error("wedge count out of range");
  a_field_order: assert property (@(posedge clk) disable iff (!resetn)
    (field == F_SAM && $past(field) != F_SAM) |-> $past(field) == F_AGC) else $error("servo mark field out of order");
  a_sample_burst: assert property (@(posedge clk) disable iff (!resetn)
    position_sample |-> $past(field) == F_BURST && field == F_IDLE) else $error("sample not at burst end");
  a_timer_resync: assert property (@(posedge clk) disable iff (!resetn)
    mark_evt |=> timer == 16'h0000) else $error("timer not restarted at mark");
  a_wedge_match: assert property (@(posedge clk) disable iff (!resetn)
    (state == S_MARK && $past(state) == S_WEDGE) |-> wedge == dwedge) else $error("sector in wrong wedge");
  a_mark_start: assert property (@(posedge clk) disable iff (!resetn)
    (state == S_MARK && !mark_evt && timer[15:4] == smark) |=> state == S_DATA) else $error("sector start missed");
  a_gate_mode: assert property (@(posedge clk) disable iff (!resetn)
    write_gate |-> preamp_write_mode && $past(preamp_write_mode)) else $error("write gate before write mode");
  a_skip_quiet: assert property (@(posedge clk) disable iff (!resetn)
    state == S_SKIP |-> !write_gate && !read_gate) else $error("gate active across wedge");
  a_parity_irq: assert property (@(posedge clk) disable iff (!resetn)
    parity_irq |-> $past(parity_enable) && !$past(parity_ok) ##1 done) else $error("parity interrupt without cause");
  a_ecc_after: assert property (@(posedge clk) disable iff (!resetn)
    ecc_valid |-> $past(state) == S_ECC && !op_write) else $error("check result outside read end");
endmodule

// ==== testbench/channel_model.sv ====
// channel and preamp stand-in: servo marks, index, serial read data, write capture
// assumes the formatter clock; one wedge every SPACING cycles, wedge 0 after the index
`timescale 1ns/100ps
module channel_model #(
  parameter int SPACING = 700
) (
  input wire logic clk,
  input wire logic read_gate,
  input wire logic write_gate,
  input wire logic nrz_write_bit,
  output logic servo_mark_found,
  output logic index_pulse,
  output logic nrz_read_bit,
  output logic nrz_read_strobe
);
  logic [7:0] tx [12];
  logic wr_bits [$];
  int t = 0;
  int w = 89;
  int c = 0;
  initial begin
    servo_mark_found = 1'b0;
    index_pulse = 1'b0;
    nrz_read_bit = 1'b0;
    nrz_read_strobe = 1'b0;
  end
  // wedge timing from the one crystal clock; index shortly before the mark of wedge 0
  always @(posedge clk) begin
    t <= (t == SPACING - 1) ? 0 : t + 1;
    if (t == SPACING - 1) w <= (w == 89) ? 0 : w + 1;
    servo_mark_found <= t < 5;
    index_pulse <= w == 89 && t > SPACING - 40 && t < SPACING - 20;
  end
  // read bits msb first, strobe rises with the bit held; idle line toggles so it never looks valid
  always @(posedge clk) begin
    if (read_gate && c < 384) begin
      c <= c + 1;
      nrz_read_bit <= tx[c / 32][7 - (c / 4) % 8];
      nrz_read_strobe <= c % 4 == 1 || c % 4 == 2;
    end else begin
      if (!read_gate) c <= 0;
      nrz_read_strobe <= 1'b0;
      nrz_read_bit <= ~nrz_read_bit;
    end
  end
  // current reversals reach the medium only under write gate
  always @(posedge clk) if (write_gate) wr_bits.push_back(nrz_write_bit);
endmodule

// ==== testbench/idless_sector_formatter_bench.sv ====
// self-checking bench: wedge counting, sector reads and writes, descriptor faults
// assumes channel_model for the pins; the bench plays the buffer controller itself
`timescale 1ns/100ps
module idless_sector_formatter_bench;
  import formatter_pkg::*;
  localparam int SB = 8;
  localparam int SPACING = 700;
  logic clk, resetn, servo_mark_found, index_pulse, position_sample, burst_window, op_start, op_write;
  logic triple_split, parity_enable, buf_req, buf_ack, busy, done, op_error, defect_hit, parity_irq;
  logic nrz_read_bit, nrz_read_strobe, read_gate, rd_word_valid, ecc_valid, corr_needed, wr_byte_valid;
  logic wr_byte_ready, write_gate, preamp_write_mode, nrz_write_bit;
  logic [6:0] wedge_count;
  logic [6:0] exp_w = 7'h00;
  logic [15:0] desc_addr, defect_addr, buf_addr, rd_word;
  logic [7:0] buf_rdata, wr_byte;
  logic [2:0] head_in, head_select;
  logic [1:0] corr_class;
  logic [7:0] mem [256];
  logic [7:0] wdata [9];
  logic wrapped = 1'b0;
  int errors = 0, checks = 0, gap = 0, bw = 0, seen = 0, widx = 0;
  idless_sector_formatter #(.SECTOR_BYTES(SB)) i_idless_sector_formatter (.clk, .resetn, .servo_mark_found,
    .index_pulse, .wedge_count, .position_sample, .burst_window, .op_start, .op_write, .triple_split,
    .parity_enable, .desc_addr, .defect_addr, .head_in, .buf_req, .buf_addr, .buf_ack, .buf_rdata, .busy,
    .done, .op_error, .defect_hit, .parity_irq, .nrz_read_bit, .nrz_read_strobe, .read_gate, .rd_word,
    .rd_word_valid, .ecc_valid, .corr_needed, .corr_class, .wr_byte, .wr_byte_valid, .wr_byte_ready,
    .write_gate, .preamp_write_mode, .head_select, .nrz_write_bit);
  channel_model #(.SPACING(SPACING)) i_channel_model (.clk, .read_gate, .write_gate, .nrz_write_bit,
    .servo_mark_found, .index_pulse, .nrz_read_bit, .nrz_read_strobe);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic exp_bit(input int j);
    return wdata[j / 8][7 - j % 8];
  endfunction
  // buffer stand-in: random wait gives answers at most every other cycle, some slower; idle data never repeats
  always @(posedge clk) begin
    buf_ack <= 1'b0;
    buf_rdata <= ~buf_rdata;
    if (buf_req && !buf_ack && $urandom_range(1, 0) == 1) begin
      buf_ack <= 1'b1;
      buf_rdata <= mem[buf_addr[7:0]];
    end
  end
  // per wedge: count, spacing from the crystal, burst length, one sample each
  always @(posedge clk) if (resetn) begin
    bw <= burst_window ? bw + 1 : 0;
    gap <= position_sample ? 1 : gap + 1;
    if (position_sample) begin
      check(wedge_count, exp_w);
      check(bw, 100);
      if (seen > 0) check(gap, SPACING);
      if (exp_w == 7'h00 && seen > 0) wrapped <= 1'b1;
      exp_w <= (exp_w == 7'h59) ? 7'h00 : exp_w + 7'h01;
      seen <= seen + 1;
    end
  end
  // one sector operation two wedges ahead; mark 12'h00D, no break
  task automatic run_op(input logic wr, input logic par_ok, input logic dfct, input logic wval);
    logic [6:0] wdg;
    logic irq;
    logic rg;
    int nw;
    int k;
    wdg = (wedge_count + 7'h02) % 7'h5A;
    mem[1] = 8'h00;
    mem[2] = 8'h0D;
    mem[0] = {^{wdg, mem[1], mem[2]} ^ par_ok, wdg};
    mem[64] = {7'h00, dfct};
    irq = 1'b0;
    rg = 1'b0;
    nw = 0;
    widx = 0;
    i_channel_model.wr_bits.delete();
    op_write <= wr;
    head_in <= 3'($urandom);
    wr_byte <= wdata[0];
    wr_byte_valid <= wval;
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    for (k = 0; k < 5000 && done !== 1'b1; k++) begin
      @(posedge clk);
      irq |= parity_irq;
      rg |= read_gate;
      if (read_gate) check(wedge_count, wdg);
      if (write_gate) check({preamp_write_mode, head_select}, {1'b1, head_in});
      if (rd_word_valid) begin
        check(rd_word, {i_channel_model.tx[2 * nw + 1], i_channel_model.tx[2 * nw]});
        nw++;
      end
      if (ecc_valid && i_channel_model.tx[0] == 8'h00) check({corr_needed, corr_class}, 3'h0);
      if (wr_byte_ready && wr_byte_valid) begin
        widx++;
        wr_byte <= wdata[widx];
      end
    end
    check(done, 1'b1);
    wr_byte_valid <= 1'b0;
    if (!par_ok) check({irq, op_error}, 2'b11);
    else if (dfct) check({defect_hit, rg}, 2'b10);
    else if (!wval) check(op_error, 1'b1);
    else if (wr) begin
      check(i_channel_model.wr_bits.size(), 8 * (SB + 4));
      for (k = 0; k < 8 * SB; k++) check(i_channel_model.wr_bits[k], exp_bit(k));
    end else check({op_error, 16'(nw)}, SB / 2);
  endtask
  initial begin
    void'($urandom(32'h5521));
    {resetn, op_start, op_write, triple_split, wr_byte_valid, buf_ack} = 6'h00;
    {head_in, wr_byte, buf_rdata} = 19'h00000;
    desc_addr = 16'h0000;
    defect_addr = 16'h0040;
    parity_enable = 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({wedge_count, busy, done, write_gate, read_gate, buf_req}, 12'h000);
    repeat (2 * SPACING) @(posedge clk);
    for (int n = 0; n < 12; n++) i_channel_model.tx[n] = 8'($urandom);
    for (int n = 0; n < 9; n++) wdata[n] = 8'($urandom);
    run_op(1'b0, 1'b1, 1'b0, 1'b1);
    for (int n = 0; n < 12; n++) i_channel_model.tx[n] = 8'h00;
    run_op(1'b0, 1'b1, 1'b0, 1'b1);
    run_op(1'b1, 1'b1, 1'b0, 1'b1);
    run_op(1'b1, 1'b1, 1'b0, 1'b0);
    run_op(1'b0, 1'b0, 1'b0, 1'b1);
    run_op(1'b0, 1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 80000 && !wrapped; k++) @(posedge clk);
    check(wrapped, 1'b1);
    tally_and_finish();
  end
  // hang guard, well past the full wedge wrap
  initial begin
    #(100000 * 40);
    errors++;
    tally_and_finish();
  end
endmodule
